// file: dram_model.sv
// dram side stand-in: counts refresh requests
// assumes refresh_req is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
`default_nettype none
module dram_model
	import refresh_ctl_pkg::*;
(
	input wire logic     sys_clk,
	input wire logic     resetn,
	input wire refresh_s refresh,
	output int           n_ref
);
	// self-refresh not modelled; only refresh requests are counted
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			n_ref <= 0;
		else if (refresh.refresh_req && refresh.refresh_enable)
			n_ref <= n_ref + 1;
	end
endmodule
`default_nettype wire

// file: refresh_ctl.sv
// refresh timer, dma single-address wait settings and dram area control
// assumes a same-clock register master; the dram sequencer consumes refresh_req
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module refresh_ctl
	import refresh_ctl_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic [1:0]  reg_byte_en,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// dram and cs space side
	output dma_wait_s        dma_wait,
	output refresh_s         refresh,
	output logic      [15:0] dram_area,
	// interrupts
	output logic             cmi_req,
	output logic             irq
);

	logic [15:0]        dma_wait_r;
	logic [15:0]        dram_area_r;
	logic [6:0]         rtcs_r;
	logic [15:0]        count_r;
	logic [15:0]        const_r;
	logic               touched_r;
	logic               cmf_armed_r;
	logic               match_r;
	logic [PRESC_W-1:0] presc_r;
	logic [EV_W-1:0]    irq_stat_r;
	logic [EV_W-1:0]    irq_mask_r;
	logic [EV_W-1:0]    stat_clr;
	logic [EV_W-1:0]    stat_set;
	logic [15:0]        rdata_r;
	logic               refresh_req_r;

	logic        hit_wait;
	logic        hit_area;
	logic        hit_rtcs;
	logic        hit_cnt;
	logic        hit_const;
	logic        hit_stat;
	logic        hit_mask;
	logic        wr_wait;
	logic        wr_area;
	logic        wr_cnt;
	logic        wr_const;
	logic        wr_rtcs;
	logic        rd_rtcs;
	logic        wr_stat;
	logic        wr_mask;
	logic [1:0]  dram_field;
	logic [3:0]  cs_field;
	logic        tick;
	logic        match_now;
	logic        match_ev;
	logic [2:0]  cks;
	logic [11:0] div_mask;

	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be, input logic [15:0] wmask);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}} & wmask;
		return (old & ~m) | (nw & m);
	endfunction

	// lane 0 carries every state bit of the narrow registers
	function automatic logic lane0_hit(input logic strobe, input logic hit, input logic [1:0] be);
		return strobe && hit && be[0];
	endfunction

	// exact match on the full byte address
	always_comb begin
		hit_wait  = reg_addr == OFS_DMA_WAIT;
		hit_area  = reg_addr == OFS_DRAM_AREA;
		hit_rtcs  = reg_addr == OFS_RTCS;
		hit_cnt   = reg_addr == OFS_RCOUNT;
		hit_const = reg_addr == OFS_RCONST;
		hit_stat  = reg_addr == OFS_IRQ_STAT;
		hit_mask  = reg_addr == OFS_IRQ_MASK;
	end

	// qualified strobes, one per register action
	always_comb begin
		wr_wait  = reg_wr && hit_wait;
		wr_area  = reg_wr && hit_area;
		wr_cnt   = reg_wr && hit_cnt;
		wr_const = reg_wr && hit_const;
		wr_rtcs  = lane0_hit(reg_wr, hit_rtcs, reg_byte_en);
		rd_rtcs  = lane0_hit(reg_rd, hit_rtcs, reg_byte_en);
		wr_stat  = lane0_hit(reg_wr, hit_stat, reg_byte_en);
		wr_mask  = lane0_hit(reg_wr, hit_mask, reg_byte_en);
	end

	// prescaler divide masks, one less than the ratio
	always_comb begin
		cks = rtcs_r[CKS_LSB+:3];
		case (cks)
			3'h1:    div_mask = 12'h001;
			3'h2:    div_mask = 12'h007;
			3'h3:    div_mask = 12'h01f;
			3'h4:    div_mask = 12'h07f;
			3'h5:    div_mask = 12'h1ff;
			3'h6:    div_mask = 12'h7ff;
			3'h7:    div_mask = 12'hfff;
			default: div_mask = 12'h000;
		endcase
	end

	// phase is not realigned on a select change, so the first tick may come early
	always_comb begin
		tick = (cks != 3'h0) && ((presc_r & div_mask) == div_mask);
	end

	// match only counts once either side has been written or the counter has counted up
	// edge detect, so a match held over several cycles flags once
	always_comb begin
		match_now = touched_r && (count_r == const_r);
		match_ev  = match_now && !match_r;
	end

	// one free-running divider serves every ratio
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			presc_r <= '0;
		else
			presc_r <= presc_r + 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			match_r <= 1'b0;
		else
			match_r <= match_now;
	end

	// counter: software write wins over count-up and match restart
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			count_r <= RST_COUNT;
		else if (wr_cnt)
			count_r <= lane_merge(count_r, reg_wdata, reg_byte_en, 16'hffff);
		else if (match_ev && rtcs_r[REFRESH_ENABLE_BIT])
			count_r <= '0;
		else if (tick)
			count_r <= count_r + 1'b1;
	end

	// constant is plain storage, all sixteen bits writable
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			const_r <= RST_COUNT;
		else if (wr_const)
			const_r <= lane_merge(const_r, reg_wdata, reg_byte_en, 16'hffff);
	end

	// a counter or constant write, or a count-up, leaves the reset state for good
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			touched_r <= 1'b0;
		else if (wr_cnt || wr_const || tick)
			touched_r <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			refresh_req_r <= 1'b0;
		else
			// one pulse per match while refresh is enabled; the dram sequencer queues it
			refresh_req_r <= match_ev && rtcs_r[REFRESH_ENABLE_BIT];
	end

	// control/status: only the low byte holds state, bit 7 is never stored
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rtcs_r <= RST_RTCS[6:0];
		end else begin
			if (wr_rtcs) begin
				rtcs_r[5:0] <= reg_wdata[5:0];
				if (!reg_wdata[CMF_BIT] && cmf_armed_r)
					rtcs_r[CMF_BIT] <= 1'b0;
			end
			// a match in the clearing cycle still leaves the flag set
			if (match_ev)
				rtcs_r[CMF_BIT] <= 1'b1;
		end
	end

	// a read that saw the flag set arms one clearing write
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			cmf_armed_r <= 1'b0;
		else if (wr_rtcs && !reg_wdata[CMF_BIT])
			cmf_armed_r <= 1'b0;
		else if (rd_rtcs && rtcs_r[CMF_BIT])
			cmf_armed_r <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			dma_wait_r <= RST_DMA_WAIT;
		else if (wr_wait)
			dma_wait_r <= lane_merge(dma_wait_r, reg_wdata, reg_byte_en, WMASK_DMA_WAIT);
	end

	// read-only bits of the area register stay zero
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			dram_area_r <= RST_DRAM_AREA;
		else if (wr_area)
			dram_area_r <= lane_merge(dram_area_r, reg_wdata, reg_byte_en, WMASK_DRAM_AREA);
	end

	// sticky status, write one to clear, set wins
	always_comb begin
		stat_clr = wr_stat ? reg_wdata[EV_W-1:0] : '0;
		stat_set = {refresh_req_r, match_ev};
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			irq_mask_r <= '0;
		else if (wr_mask)
			irq_mask_r <= reg_wdata[EV_W-1:0];
	end

	// read data stands one cycle; unmapped reads return zero
	// byte reads get the whole word; the master picks its lane
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (1'b1)
				hit_wait:  rdata_r <= dma_wait_r;
				hit_area:  rdata_r <= dram_area_r;
				hit_rtcs:  rdata_r <= {9'h000, rtcs_r};
				hit_cnt:   rdata_r <= count_r;
				hit_const: rdata_r <= const_r;
				hit_stat:  rdata_r <= {{(16-EV_W){1'b0}}, irq_stat_r};
				hit_mask:  rdata_r <= {{(16-EV_W){1'b0}}, irq_mask_r};
				default:   rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	always_comb begin
		dram_field = dma_wait_r[DDW_LSB+:2];
		cs_field   = dma_wait_r[DSW_LSB+:4];
	end

	// decoded wait settings for the single-address dma sequencer
	// the wait pin itself is sampled by the sequencer, not here
	always_comb begin
		dma_wait.dram_cycles      = DRAM_BASE_CYCLES + {1'b0, dram_field};
		dma_wait.dram_ext_wait_en = dram_field >= DRAM_EXT_WAIT_MIN;
		dma_wait.cs_waits         = cs_field;
		dma_wait.cs_ext_wait_en   = cs_field != 4'h0;
	end

	// refresh mode and enable go straight to the dram sequencer
	always_comb begin
		refresh.refresh_req    = refresh_req_r;
		refresh.refresh_enable = rtcs_r[REFRESH_ENABLE_BIT];
		refresh.self_refresh   = rtcs_r[RMD_BIT];
	end

	// outputs straight from state or its decode
	assign reg_rdata = rdata_r;
	assign dram_area = dram_area_r;
	assign cmi_req   = rtcs_r[CMF_BIT] && rtcs_r[COMPARE_MATCH_IRQ_ENABLE_BIT];
	assign irq       = |(irq_stat_r & irq_mask_r);

endmodule

`default_nettype wire

// file: refresh_ctl_asserts.sv
// checker for the refresh and dma wait block
// sees only the top ports, one clock domain
`timescale 1ns/1ns
`default_nettype none
module refresh_ctl_chk
	import refresh_ctl_pkg::*;
(
	input wire logic        sys_clk, resetn, reg_wr, reg_rd, cmi_req, irq,
	input wire logic [31:0] reg_addr,
	input wire logic [15:0] reg_wdata, reg_rdata, dram_area,
	input wire logic [1:0]  reg_byte_en,
	input wire dma_wait_s   dma_wait,
	input wire refresh_s    refresh
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire logic wr0 = reg_wr && reg_byte_en[0];
	a_dram_len: assert property (dma_wait.dram_ext_wait_en == (dma_wait.dram_cycles >= 3'h4)
		&& dma_wait.dram_cycles inside {[3'h2:3'h5]}) else $error("dram length");
	a_cs_ext: assert property (dma_wait.cs_ext_wait_en == (dma_wait.cs_waits != 4'h0))
		else $error("cs wait enable");
	a_cs_write: assert property (wr0 && reg_addr == OFS_DMA_WAIT |=>
		{12'h0, dma_wait.cs_waits} == ($past(reg_wdata) & 16'h000f)) else $error("cs waits");
	a_rtcs_rd: assert property (reg_rd && reg_addr == OFS_RTCS |=> reg_rdata[15:7] == 9'h0)
		else $error("rtcs upper bits");
	a_mode_write: assert property (wr0 && reg_addr == OFS_RTCS |=>
		{14'h0, refresh.refresh_enable, refresh.self_refresh} == ($past(reg_wdata) & 16'h0003))
		else $error("refresh mode");
	a_req_pulse: assert property (refresh.refresh_req |=> !refresh.refresh_req)
		else $error("request width");
	a_req_enable: assert property (refresh.refresh_req |-> $past(refresh.refresh_enable))
		else $error("request while off");
	a_cmi_clear: assert property ($fell(cmi_req) |-> $past(reg_wr))
		else $error("cmi fell without write");
endmodule
bind refresh_ctl refresh_ctl_chk u_chk (.sys_clk, .resetn, .reg_wr, .reg_rd, .cmi_req, .irq,
	.reg_addr, .reg_wdata, .reg_rdata, .dram_area, .reg_byte_en, .dma_wait, .refresh);
`default_nettype wire

// file: refresh_ctl_pkg.sv
// constants, field layouts and carrier types for the refresh and dma wait block
// assumes a 16-bit register port with byte lanes, one clock domain
package refresh_ctl_pkg;

	localparam logic [31:0] OFS_DMA_WAIT  = 32'hffff8626;
	localparam logic [31:0] OFS_DRAM_AREA = 32'hffff862a;
	localparam logic [31:0] OFS_RTCS      = 32'hffff862c;
	localparam logic [31:0] OFS_RCOUNT    = 32'hffff8640;
	localparam logic [31:0] OFS_RCONST    = 32'hffff8642;
	localparam logic [31:0] OFS_IRQ_STAT  = 32'hffff8644;
	localparam logic [31:0] OFS_IRQ_MASK  = 32'hffff8646;

	localparam logic [15:0] RST_DMA_WAIT  = 16'h000f;
	localparam logic [15:0] RST_DRAM_AREA = 16'h0000;
	localparam logic [15:0] RST_RTCS      = 16'h0000;
	localparam logic [15:0] RST_COUNT     = 16'h0000;

	// writable bit masks; other bits read zero
	localparam logic [15:0] WMASK_DMA_WAIT  = 16'h003f;
	localparam logic [15:0] WMASK_DRAM_AREA = 16'hffb7;

	// refresh control/status field positions
	localparam int CMF_BIT  = 6;
	localparam int COMPARE_MATCH_IRQ_ENABLE_BIT = 5;
	localparam int CKS_LSB  = 2;
	localparam int REFRESH_ENABLE_BIT = 1;
	localparam int RMD_BIT  = 0;

	// dma wait field positions
	localparam int DDW_LSB = 4;
	localparam int DSW_LSB = 0;

	// dram access base length and wait threshold for external wait
	localparam logic [2:0] DRAM_BASE_CYCLES = 3'h2;
	localparam logic [1:0] DRAM_EXT_WAIT_MIN = 2'h2;

	// interrupt status bit positions
	localparam int EV_MATCH   = 0;
	localparam int EV_REFRESH = 1;
	localparam int EV_W       = 2;

	localparam int PRESC_W = 12;

	typedef struct packed {
		logic [2:0] dram_cycles;
		logic       dram_ext_wait_en;
		logic [3:0] cs_waits;
		logic       cs_ext_wait_en;
	} dma_wait_s;

	typedef struct packed {
		logic refresh_req;
		logic refresh_enable;
		logic self_refresh;
	} refresh_s;

endpackage

// file: tb_refresh_ctl.sv
// bench for the refresh and dma wait block
// assumes the register port of the design notes
`timescale 1ns/1ns
`default_nettype none
module tb_refresh_ctl import refresh_ctl_pkg::*;;
	logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, cmi_req, irq;
	logic [31:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata, dram_area;
	logic [1:0]  reg_byte_en = 2'h3;
	dma_wait_s   dma_wait;
	refresh_s    refresh;
	int          n_mismatch = 0, tests_run = 0, n_ref, i;
	refresh_ctl DUT (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr, .reg_rd,
		.reg_rdata, .dma_wait, .refresh, .dram_area, .cmi_req, .irq);
	dram_model u_dram (.sys_clk, .resetn, .refresh, .n_ref);
	initial forever #5 sys_clk = ~sys_clk;
	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [31:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// bounded: a lost request must not hang the run
	task automatic wait_ref(input int n);
		for (int k = 0; k < 300 && n_ref < n; k++)
			@(posedge sys_clk) #1;
		if (n_ref < n) begin
			n_mismatch++;
			$display("mismatch at %0t: no refresh", $time);
			stop_test();
		end
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		rc(OFS_DMA_WAIT, 16'h000f);
		for (i = 0; i < 4; i++) begin
			wr(OFS_DMA_WAIT, 16'(i * 21));
			chk(16'(dma_wait), 16'({3'(i + 2), i >= 2, 4'(i * 5), i != 0}));
			rc(OFS_DMA_WAIT, 16'(i * 21));
		end
		rc(OFS_RTCS, 16'h0000);
		rc(32'hffff8650, 16'h0000);
		wr(OFS_DRAM_AREA, 16'hffff);
		rc(OFS_DRAM_AREA, WMASK_DRAM_AREA);
		chk(dram_area, WMASK_DRAM_AREA);
		wr(OFS_RTCS, 16'hffc3);
		rc(OFS_RTCS, 16'h0003);
		chk(16'({refresh.refresh_enable, refresh.self_refresh}), 16'h3);
		wr(OFS_RCONST, 16'h0003);
		wr(OFS_RCOUNT, 16'h0000);
		wr(OFS_IRQ_MASK, 16'h0000);
		wr(OFS_RTCS, 16'h0026);
		wait_ref(1);
		chk(16'({cmi_req, irq}), 16'h2);
		wr(OFS_IRQ_MASK, 16'h0001);
		chk(16'(irq), 16'h1);
		wr(OFS_RTCS, 16'h0022);
		chk(16'(cmi_req), 16'h1);
		rc(OFS_RTCS, 16'h0062);
		wr(OFS_RTCS, 16'h0022);
		chk(16'(cmi_req), 16'h0);
		wr(OFS_IRQ_STAT, 16'h0003);
		chk(16'(irq), 16'h0);
		wr(OFS_RTCS, 16'h0006);
		wait_ref(n_ref + 1);
		chk(16'(cmi_req), 16'h0);
		rc(OFS_RTCS, 16'h0046);
		wr(OFS_RTCS, 16'h0004);
		wr(OFS_RCOUNT, 16'h0000);
		wr(OFS_IRQ_STAT, 16'h0003);
		i = n_ref;
		repeat (20) @(posedge sys_clk);
		#1 chk(16'(n_ref), 16'(i));
		rc(OFS_IRQ_STAT, 16'h0001);
		stop_test();
	end
endmodule
`default_nettype wire
